// ---- rtl/ipl_regs.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ipl_map.vh"

module ipl_regs #(
    parameter NUM_SRC  = 25,
    parameter ADDR_W   = 8,
    parameter DATA_W   = 16
) (
    // clock and reset
    input  wire                   clock_in,
    input  wire                   nrst_in,
    // register port
    input  wire [ADDR_W-1:0]      addr_in,
    input  wire [DATA_W-1:0]      wdata_in,
    input  wire                   wr_in,
    input  wire                   rd_in,
    output reg  [DATA_W-1:0]      rdata_out,
    // request sources
    input  wire                   ext_req_a_in,
    input  wire                   ext_req_b_in,
    input  wire [NUM_SRC-3:0]     periph_req_in,
    // towards arbitration
    output reg  [NUM_SRC-1:0]     fwd_req_out,
    output reg  [2*NUM_SRC-1:0]   fwd_level_out,
    // event interrupt
    output reg                    irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // source index to field position

    function [5:0] src_pos;
        input integer idx;
        begin
            case (idx)
                0:       src_pos = `IPL_POS_EXT_A;
                1:       src_pos = `IPL_POS_EXT_B;
                2:       src_pos = `IPL_POS_LOW_VOLT;
                3:       src_pos = `IPL_POS_PLL_UNLOCK;
                4:       src_pos = `IPL_POS_FLASH_ERR;
                5:       src_pos = `IPL_POS_CAN_BOFF;
                6:       src_pos = `IPL_POS_CAN_ERR;
                7:       src_pos = `IPL_POS_CAN_WAKE;
                8:       src_pos = `IPL_POS_CAN_MSG;
                9:       src_pos = `IPL_POS_PORT_F;
                10:      src_pos = `IPL_POS_PORT_E;
                11:      src_pos = `IPL_POS_PORT_D;
                12:      src_pos = `IPL_POS_PORT_C;
                13:      src_pos = `IPL_POS_PORT_B;
                14:      src_pos = `IPL_POS_PORT_A;
                15:      src_pos = `IPL_POS_SER1_RX;
                16:      src_pos = `IPL_POS_SER1_TX;
                17:      src_pos = `IPL_POS_SER0_RX;
                18:      src_pos = `IPL_POS_SER0_TX;
                19:      src_pos = `IPL_POS_UART1_TXE;
                20:      src_pos = `IPL_POS_UART1_TXI;
                21:      src_pos = `IPL_POS_UART1_RXE;
                22:      src_pos = `IPL_POS_UART1_RXF;
                23:      src_pos = `IPL_POS_DEC1_HOME;
                default: src_pos = `IPL_POS_DEC1_INDEX;
            endcase
        end
    endfunction

    // writable bits of a mapped priority register; zero elsewhere
    function [DATA_W-1:0] wr_mask;
        input [ADDR_W-1:0] a;
        begin
            case (a)
                `IPL_OFF_REG_TWO:   wr_mask = `IPL_WMASK_TWO;
                `IPL_OFF_REG_THREE: wr_mask = `IPL_WMASK_THREE;
                `IPL_OFF_REG_FOUR:  wr_mask = `IPL_WMASK_FOUR;
                `IPL_OFF_REG_FIVE:  wr_mask = `IPL_WMASK_FIVE;
                default:            wr_mask = {DATA_W{1'b0}};
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    reg  [DATA_W-1:0]  prio_two_q;
    reg  [DATA_W-1:0]  prio_three_q;
    reg  [DATA_W-1:0]  prio_four_q;
    reg  [DATA_W-1:0]  prio_five_q;
    reg  [DATA_W-1:0]  irq_status_q;
    reg  [DATA_W-1:0]  irq_mask_q;
    reg  [1:0]         ext_a_sync_q;
    reg  [1:0]         ext_b_sync_q;
    reg  [NUM_SRC-1:0] req_prev_q;

    reg  [DATA_W-1:0]  irq_status_d;
    reg  [DATA_W-1:0]  irq_mask_d;
    reg  [DATA_W-1:0]  rdata_d;
    reg  [DATA_W-1:0]  cur_word;
    reg  [DATA_W-1:0]  new_word;
    reg  [DATA_W-1:0]  evt_set;

    wire [63:0]          prio_all;
    wire [NUM_SRC-1:0]   req_now;
    wire [NUM_SRC-1:0]   src_en;
    wire [2*NUM_SRC-1:0] src_lvl;
    wire [DATA_W-1:0]    wmask;
    wire                 prio_hit;

    assign prio_all = {prio_five_q, prio_four_q, prio_three_q, prio_two_q};
    assign wmask    = wr_mask(addr_in);
    assign prio_hit = (wmask != {DATA_W{1'b0}});

    ////////////////////////////////////////////////////////////////////////////
    // external request pins come from outside: two flops before use

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            ext_a_sync_q <= 2'h0;
            ext_b_sync_q <= 2'h0;
        end else begin
            ext_a_sync_q <= {ext_a_sync_q[0], ext_req_a_in};
            ext_b_sync_q <= {ext_b_sync_q[0], ext_req_b_in};
        end
    end

    assign req_now = {periph_req_in, ext_b_sync_q[1], ext_a_sync_q[1]};

    ////////////////////////////////////////////////////////////////////////////
    // per-source decode

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g = g + 1) begin : g_src
            ipl_level_dec u_dec (
                .field_in   (prio_all[src_pos(g) +: 2]),
                .enable_out (src_en[g]),
                .level_out  (src_lvl[2*g +: 2])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // priority registers

    always @* begin
        case (addr_in)
            `IPL_OFF_REG_TWO:   cur_word = prio_two_q;
            `IPL_OFF_REG_THREE: cur_word = prio_three_q;
            `IPL_OFF_REG_FOUR:  cur_word = prio_four_q;
            `IPL_OFF_REG_FIVE:  cur_word = prio_five_q;
            default:            cur_word = {DATA_W{1'b0}};
        endcase
        new_word = wdata_in & wmask;
    end

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            prio_two_q   <= `IPL_RST_PRIO;
            prio_three_q <= `IPL_RST_PRIO;
            prio_four_q  <= `IPL_RST_PRIO;
            prio_five_q  <= `IPL_RST_PRIO;
        end else if (wr_in) begin
            case (addr_in)
                `IPL_OFF_REG_TWO:   prio_two_q   <= new_word;
                `IPL_OFF_REG_THREE: prio_three_q <= new_word;
                `IPL_OFF_REG_FOUR:  prio_four_q  <= new_word;
                `IPL_OFF_REG_FIVE:  prio_five_q  <= new_word;
                default:            prio_two_q   <= prio_two_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // events, status and mask

    // a rising request on a disabled source is dropped, but software hears of it
    always @* begin
        evt_set = {DATA_W{1'b0}};
        evt_set[`IPL_EVT_BLOCKED] = |(req_now & ~req_prev_q & ~src_en);
        evt_set[`IPL_EVT_RSVD_WR] = wr_in && prio_hit &&
                                    ((wdata_in & ~wmask) != {DATA_W{1'b0}});
        evt_set[`IPL_EVT_LVL_CHG] = wr_in && prio_hit && (new_word != cur_word);
    end

    always @* begin
        irq_status_d = irq_status_q;
        irq_mask_d   = irq_mask_q;
        if (wr_in && addr_in == `IPL_OFF_IRQ_STATUS) begin
            irq_status_d = irq_status_q & ~wdata_in;
        end
        if (wr_in && addr_in == `IPL_OFF_IRQ_MASK) begin
            irq_mask_d = wdata_in & `IPL_WMASK_IRQ;
        end
        // set after clear so a same-cycle event survives
        irq_status_d = (irq_status_d | evt_set) & `IPL_WMASK_IRQ;
    end

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            irq_status_q <= `IPL_RST_IRQ;
            irq_mask_q   <= `IPL_RST_IRQ;
            req_prev_q   <= {NUM_SRC{1'b0}};
            irq_out      <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            irq_mask_q   <= irq_mask_d;
            req_prev_q   <= req_now;
            irq_out      <= |(irq_status_d & irq_mask_d);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // forwarding to arbitration, registered so outputs come from flops

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            fwd_req_out   <= {NUM_SRC{1'b0}};
            fwd_level_out <= {2*NUM_SRC{1'b0}};
        end else begin
            fwd_req_out   <= req_now & src_en;
            fwd_level_out <= src_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data valid in the cycle after the strobe only

    always @* begin
        rdata_d = {DATA_W{1'b0}};
        if (rd_in) begin
            case (addr_in)
                `IPL_OFF_REG_TWO:    rdata_d = prio_two_q & `IPL_WMASK_TWO;
                `IPL_OFF_REG_THREE:  rdata_d = prio_three_q & `IPL_WMASK_THREE;
                `IPL_OFF_REG_FOUR:   rdata_d = prio_four_q & `IPL_WMASK_FOUR;
                `IPL_OFF_REG_FIVE:   rdata_d = prio_five_q & `IPL_WMASK_FIVE;
                `IPL_OFF_IRQ_STATUS: rdata_d = irq_status_q;
                `IPL_OFF_IRQ_MASK:   rdata_d = irq_mask_q;
                default:             rdata_d = {DATA_W{1'b0}};
            endcase
        end
    end

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            rdata_out <= {DATA_W{1'b0}};
        end else begin
            rdata_out <= rdata_d;
        end
    end

endmodule // ipl_regs

`default_nettype wire

// ---- rtl/ipl_map.vh ----
`ifndef IPL_MAP_VH
`define IPL_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register word offsets
`define IPL_OFF_REG_TWO     8'h02
`define IPL_OFF_REG_THREE   8'h03
`define IPL_OFF_REG_FOUR    8'h04
`define IPL_OFF_REG_FIVE    8'h05
`define IPL_OFF_IRQ_STATUS  8'h10
`define IPL_OFF_IRQ_MASK    8'h11

////////////////////////////////////////////////////////////////////////////////
// reset values and writable bits (reserved bits are zero here)
`define IPL_RST_PRIO        16'h0000
`define IPL_RST_IRQ         16'h0000
`define IPL_WMASK_TWO       16'h0FCF
`define IPL_WMASK_THREE     16'hFFFC
`define IPL_WMASK_FOUR      16'hFC3F
`define IPL_WMASK_FIVE      16'hFF3F
`define IPL_WMASK_IRQ       16'h0007

////////////////////////////////////////////////////////////////////////////////
// field encodings
`define IPL_FIELD_OFF       2'h0
`define IPL_FIELD_L0        2'h1
`define IPL_FIELD_L1        2'h2
`define IPL_FIELD_L2        2'h3

////////////////////////////////////////////////////////////////////////////////
// field low bit inside the 64-bit image {five, four, three, two}
`define IPL_POS_EXT_A       6'd0
`define IPL_POS_EXT_B       6'd2
`define IPL_POS_LOW_VOLT    6'd6
`define IPL_POS_PLL_UNLOCK  6'd8
`define IPL_POS_FLASH_ERR   6'd10
`define IPL_POS_CAN_BOFF    6'd18
`define IPL_POS_CAN_ERR     6'd20
`define IPL_POS_CAN_WAKE    6'd22
`define IPL_POS_CAN_MSG     6'd24
`define IPL_POS_PORT_F      6'd26
`define IPL_POS_PORT_E      6'd28
`define IPL_POS_PORT_D      6'd30
`define IPL_POS_PORT_C      6'd32
`define IPL_POS_PORT_B      6'd34
`define IPL_POS_PORT_A      6'd36
`define IPL_POS_SER1_RX     6'd42
`define IPL_POS_SER1_TX     6'd44
`define IPL_POS_SER0_RX     6'd46
`define IPL_POS_SER0_TX     6'd48
`define IPL_POS_UART1_TXE   6'd50
`define IPL_POS_UART1_TXI   6'd52
`define IPL_POS_UART1_RXE   6'd56
`define IPL_POS_UART1_RXF   6'd58
`define IPL_POS_DEC1_HOME   6'd60
`define IPL_POS_DEC1_INDEX  6'd62

////////////////////////////////////////////////////////////////////////////////
// event status bits
`define IPL_EVT_BLOCKED     0
`define IPL_EVT_RSVD_WR     1
`define IPL_EVT_LVL_CHG     2

`endif

// ---- rtl/ipl_level_dec.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ipl_map.vh"

module ipl_level_dec (
    // programmed field
    input  wire [1:0] field_in,
    // decoded result
    output wire       enable_out,
    output wire [1:0] level_out
);

    // only three levels exist, so level 3 can never come out
    assign enable_out = (field_in != `IPL_FIELD_OFF);
    assign level_out  = enable_out ? (field_in - 2'h1) : 2'h0;

endmodule // ipl_level_dec

`default_nettype wire

// ---- testbench/ipl_regs_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ipl_regs_chk #(
    parameter NUM_SRC = 25,
    parameter ADDR_W  = 8,
    parameter DATA_W  = 16
) (
    // clock, reset and register port
    input wire logic                 clock_in,
    input wire logic                 nrst_in,
    input wire logic [ADDR_W-1:0]    addr_in,
    input wire logic [DATA_W-1:0]    wdata_in,
    input wire logic                 wr_in,
    input wire logic                 rd_in,
    input wire logic [DATA_W-1:0]    rdata_out,
    // sources and arbitration side
    input wire logic                 ext_req_a_in,
    input wire logic                 ext_req_b_in,
    input wire logic [NUM_SRC-3:0]   periph_req_in,
    input wire logic [NUM_SRC-1:0]   fwd_req_out,
    input wire logic [2*NUM_SRC-1:0] fwd_level_out,
    input wire logic                 irq_out
);
    // a pair reading 11 would be the unreachable top level
    wire [2*NUM_SRC-1:0] hi_lo = fwd_level_out & (fwd_level_out >> 1);
    wire                 top_lvl = |(hi_lo & {NUM_SRC{2'b01}});
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    property rb_p(a, m);
        wr_in && addr_in == a ##1 rd_in && addr_in == a |=> rdata_out == ($past(wdata_in, 2) & m);
    endproperty
    reg2_rb_a: assert property (rb_p(8'h02, 16'h0FCF)) else $error("reg two readback");
    reg3_rb_a: assert property (rb_p(8'h03, 16'hFFFC)) else $error("reg three readback");
    reg4_rb_a: assert property (rb_p(8'h04, 16'hFC3F)) else $error("reg four readback");
    reg5_rb_a: assert property (rb_p(8'h05, 16'hFF3F)) else $error("reg five readback");
    unmapped_zero_a: assert property (rd_in && addr_in == 8'h20 |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (!rd_in |=> rdata_out == 16'h0000)
        else $error("read data outside read slot");
    level_range_a: assert property (!top_lvl) else $error("level three forwarded");
    fwd_gate_a: assert property (1'b1 |=> (fwd_req_out[NUM_SRC-1:2] & ~$past(periph_req_in)) == '0)
        else $error("request forwarded without source");
    reset_clean_a: assert property ($rose(nrst_in) |-> fwd_req_out == '0 && !irq_out)
        else $error("outputs not clear after reset");
    mask_off_a: assert property (wr_in && addr_in == 8'h11 && wdata_in[2:0] == 3'h0 |=> !irq_out)
        else $error("masked interrupt raised");
    cover property (wr_in && addr_in == 8'h02 ##1 rd_in);
    cover property (irq_out);
    cover property (fwd_req_out[0]);
endmodule // ipl_regs_chk
bind ipl_regs ipl_regs_chk #(.NUM_SRC(NUM_SRC), .ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (
    .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_req_a_in(ext_req_a_in),
    .ext_req_b_in(ext_req_b_in), .periph_req_in(periph_req_in), .fwd_req_out(fwd_req_out),
    .fwd_level_out(fwd_level_out), .irq_out(irq_out));
`default_nettype wire

// ---- testbench/ipl_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ipl_src_model (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    // wanted request levels, in source order
    input  wire logic [24:0] pat_in,
    // request lines
    output var logic         ext_a_out,
    output var logic         ext_b_out,
    output var logic [22:0]  periph_out
);
    // flags follow their event one clock late, as a registered peripheral flag does
    // held low while reset is asserted, so the first edge under reset clears them
    always @(posedge clock_in) begin
        {periph_out, ext_b_out, ext_a_out} <= nrst_in ? pat_in : 25'h0;
    end
endmodule // ipl_src_model
`default_nettype wire

// ---- testbench/ipl_regs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module ipl_regs_bench;
    logic        clock_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [24:0] pat = 25'h0;
    wire  [15:0] rdata_out;
    wire         ext_a, ext_b, irq_out;
    wire  [22:0] periph;
    wire  [24:0] fwd_req_out;
    wire  [49:0] fwd_level_out;
    integer      failures = 0;
    integer      num_checks = 0;
    integer      seed = 32'h65a3;
    integer      cycles = 0;
    logic [63:0] img = 64'h0;
    logic [15:0] got, d;
    logic [7:0]  a;
    int          pos[25] = '{0,2,6,8,10,18,20,22,24,26,28,30,32,34,36,42,44,46,48,50,52,56,58,60,62};
    ipl_regs #(.NUM_SRC(25), .ADDR_W(8), .DATA_W(16)) dut (
        .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_req_a_in(ext_a),
        .ext_req_b_in(ext_b), .periph_req_in(periph), .fwd_req_out(fwd_req_out),
        .fwd_level_out(fwd_level_out), .irq_out(irq_out));
    ipl_src_model src (.clock_in(clock_in), .nrst_in(nrst_in), .pat_in(pat),
        .ext_a_out(ext_a), .ext_b_out(ext_b), .periph_out(periph));
    always #5 clock_in = ~clock_in;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] wm(input logic [7:0] ra);
        case (ra)
            8'h02: wm = 16'h0FCF;
            8'h03: wm = 16'hFFFC;
            8'h04: wm = 16'hFC3F;
            8'h05: wm = 16'hFF3F;
            default: wm = 16'h0000;
        endcase
    endfunction
    function automatic logic [74:0] fwd_exp(input logic [24:0] rq);
        logic [1:0] f;
        fwd_exp = '0;
        for (int i = 0; i < 25; i++) begin
            f = img[pos[i]+:2];
            fwd_exp[50+i] = rq[i] && f != 2'h0;
            fwd_exp[2*i+:2] = (f == 2'h0) ? 2'h0 : f - 2'h1;
        end
    endfunction
    // got holds what rdata_out showed in the cycle that just ended
    task automatic bus(input logic w, r, input logic [7:0] ba, input logic [15:0] bd);
        wr_in <= w;
        rd_in <= r;
        addr_in <= ba;
        wdata_in <= bd;
        @(posedge clock_in);
        got = rdata_out;
    endtask
    task automatic chk_reg(input string n, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_fwd(input logic [74:0] e);
        num_checks++;
        if ({fwd_req_out, fwd_level_out} !== e) begin
            failures++;
            $display("BAD forward expected %h seen %h", e, {fwd_req_out, fwd_level_out});
        end
    endtask
    task automatic rdc(input logic [7:0] ra, input logic [15:0] e, input string n);
        bus(1'b0, 1'b1, ra, 16'h0000);
        bus(1'b0, 1'b0, 8'h00, 16'h0000);
        chk_reg(n, e, got);
    endtask
    task automatic wr(input logic [7:0] ra, input logic [15:0] rd);
        bus(1'b1, 1'b0, ra, rd);
        if (wm(ra) != 16'h0000) img[(ra-2)*16+:16] = rd & wm(ra);
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // a few hundred cycles are needed; the ceiling leaves wide margin
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            summarize;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'b1;
        @(posedge clock_in);
        for (int i = 2; i < 6; i++) rdc(i[7:0], 16'h0000, "reset value");
        rdc(8'h10, 16'h0000, "status reset");
        rdc(8'h11, 16'h0000, "mask reset");
        for (int i = 2; i < 6; i++) begin
            wr(i[7:0], 16'hFFFF);
            rdc(i[7:0], wm(i[7:0]), "reserved bits");
        end
        wr(8'h20, 16'hFFFF);
        rdc(8'h20, 16'h0000, "unmapped");
        $display("test reset and layout done");
        for (int n = 0; n < 24; n++) begin
            a = 8'h02 + 8'($random(seed) & 3);
            d = $random(seed);
            wr(a, d);
            rdc(a, d & wm(a), "readback");
            pat <= $random(seed);
            repeat (5) bus(1'b0, 1'b0, 8'h00, 16'h0000);
            chk_fwd(fwd_exp(pat));
        end
        $display("test random levels done");
        pat <= 25'h0;
        wr(8'h11, 16'h0000);
        wr(8'h10, 16'hFFFF);
        wr(8'h02, ~img[15:0] & 16'h0FCF);
        rdc(8'h10, 16'h0004, "status change");
        chk_reg("irq masked", 16'h0000, {15'h0, irq_out});
        wr(8'h11, 16'h0004);
        rdc(8'h11, 16'h0004, "mask");
        chk_reg("irq raised", 16'h0001, {15'h0, irq_out});
        wr(8'h10, 16'h0004);
        bus(1'b0, 1'b0, 8'h00, 16'h0000);
        chk_reg("irq cleared", 16'h0000, {15'h0, irq_out});
        // keep the field bits as they are so only the reserved-write event fires
        wr(8'h03, img[31:16] | 16'h0003);
        rdc(8'h10, 16'h0002, "status reserved");
        // source 0 stays disabled while its request rises
        wr(8'h02, 16'h0FCC);
        wr(8'h10, 16'hFFFF);
        wr(8'h11, 16'h0001);
        pat <= 25'h1;
        repeat (5) bus(1'b0, 1'b0, 8'h00, 16'h0000);
        chk_fwd(fwd_exp(pat));
        rdc(8'h10, 16'h0001, "status blocked");
        chk_reg("irq blocked", 16'h0001, {15'h0, irq_out});
        $display("test interrupt done");
        // reset again in mid-run with a request still high
        nrst_in <= 1'b0;
        repeat (2) bus(1'b0, 1'b0, 8'h00, 16'h0000);
        nrst_in <= 1'b1;
        img = 64'h0;
        for (int i = 2; i < 6; i++) rdc(i[7:0], 16'h0000, "reset again");
        chk_fwd(fwd_exp(pat));
        $display("test mid-run reset done");
        summarize;
    end
endmodule // ipl_regs_bench
`default_nettype wire
